// *** verilog/sfp_defines.svh ***
// Timing counts, widths and polarity defaults of the slave FIFO port
`ifndef SFP_DEFINES_SVH
`define SFP_DEFINES_SVH
`define SFP_ADDR_SETUP_NS 25
`define SFP_CLK_PERIOD_NS 50
`define SFP_ADDR_SETUP_CYC \
    ((`SFP_ADDR_SETUP_NS + `SFP_CLK_PERIOD_NS - 1) / `SFP_CLK_PERIOD_NS)
`define SFP_NUM_FIFOS 4
`define SFP_DATA_W 16
`define SFP_DEPTH 64
`define SFP_POL_RESET 6'h00
`define SFP_POL_SEL 0
`define SFP_POL_OE 1
`define SFP_POL_RD 2
`define SFP_POL_WR 3
`define SFP_POL_PKT 4
`define SFP_POL_FLAG 5
`endif

// *** verilog/sfp_pkg.sv ***
// Types of the slave FIFO port
package sfp_pkg;
    typedef enum logic [1:0] {
        SFP_IDLE,
        SFP_READ,
        SFP_WRITE
    } sfp_op_t;
endpackage

// *** verilog/sfp_endpoint.sv ***
// One endpoint FIFO: storage, pointers, count and commit logic
`include "sfp_defines.svh"
module sfp_endpoint #(
    parameter int DATA_W = `SFP_DATA_W,
    parameter int DEPTH = `SFP_DEPTH,
    parameter int AW = $clog2(DEPTH)
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Strobes already qualified by edge; read and write also by select
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic commit_i,
    input wire logic edge_i,
    input wire logic [DATA_W-1:0] wdata_i,
    // Auto commit setup
    input wire logic auto_mode_i,
    input wire logic [AW:0] auto_len_i,
    // State
    output logic [DATA_W-1:0] head_o,
    output logic empty_o,
    output logic full_o,
    output logic commit_o,
    output logic drop_o
);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic [AW:0] pkt;
        logic auto_last;
        logic empty;
        logic full;
        logic commit;
        logic drop;
    } sfp_ep_t;

    logic [DATA_W-1:0] mem [DEPTH];
    sfp_ep_t s_r, s_nxt;
    logic do_wr, do_rd;

    assign do_wr = wr_i && !s_r.full;
    assign do_rd = rd_i && !s_r.empty;
    assign head_o = mem[s_r.rp]; // Prefetched word at pointer
    assign empty_o = s_r.empty;
    assign full_o = s_r.full;
    assign commit_o = s_r.commit;
    assign drop_o = s_r.drop;

    // Storage written on every accepted write edge
    always_ff @(posedge core_clk_i) begin
        if (do_wr) begin
            mem[s_r.wp] <= wdata_i;
        end
    end

    // Pointers, count and packet commit
    always_comb begin
        logic [AW:0] c;
        logic [AW:0] p;
        c = s_r.cnt;
        p = s_r.pkt;
        s_nxt = s_r;
        s_nxt.commit = 1'b0;
        s_nxt.drop = 1'b0;
        // An auto close guards only the next link edge, however far off
        if (edge_i) begin
            s_nxt.auto_last = 1'b0;
        end
        if (do_wr) begin
            s_nxt.wp = s_r.wp + 1'b1;
            p = p + 1'b1;
        end
        if (do_rd) begin
            s_nxt.rp = s_r.rp + 1'b1;
        end
        c = c + (AW + 1)'(do_wr) - (AW + 1)'(do_rd);
        if (auto_mode_i && do_wr && p >= auto_len_i) begin
            // Auto packet closes; a commit on this edge is swallowed
            s_nxt.commit = 1'b1;
            s_nxt.auto_last = 1'b1;
            s_nxt.drop = commit_i;
            p = '0;
        end else if (commit_i) begin
            // Same-edge word already counted in p
            if (s_r.auto_last && p <= (AW + 1)'(1)) begin
                s_nxt.drop = 1'b1;
            end else begin
                s_nxt.commit = 1'b1;
            end
            p = '0;
        end
        s_nxt.cnt = c;
        s_nxt.pkt = p;
        s_nxt.empty = (c == '0); // Flags follow the pointers
        s_nxt.full = (c == (AW + 1)'(DEPTH));
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_r <= '{empty: 1'b1, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule

// *** verilog/sfp_port.sv ***
// Slave FIFO port top: pin sampling, polarity, select and bus drive
`include "sfp_defines.svh"
module sfp_port #(
    parameter int DATA_W = `SFP_DATA_W,
    parameter int DEPTH = `SFP_DEPTH,
    parameter int NUM_FIFOS = `SFP_NUM_FIFOS,
    parameter int AW = $clog2(DEPTH),
    parameter int SW = $clog2(NUM_FIFOS)
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Link pins from the external master
    input wire logic interface_clock_i,
    input wire logic port_select_n_i,
    input wire logic bus_output_enable_i,
    input wire logic fifo_read_strobe_i,
    input wire logic fifo_write_strobe_i,
    input wire logic packet_commit_strobe_i,
    input wire logic [SW-1:0] fifo_select_lines_i,
    // Data bus as three signals
    input wire logic [DATA_W-1:0] data_i,
    output logic [DATA_W-1:0] data_o,
    output logic data_oe_o,
    // Static configuration
    input wire logic [5:0] polarity_i,
    input wire logic [NUM_FIFOS-1:0] auto_mode_i,
    input wire logic [AW:0] auto_commit_length_i,
    // Status flags and packet events
    output logic [NUM_FIFOS-1:0] empty_flag_o,
    output logic [NUM_FIFOS-1:0] full_flag_o,
    output logic [NUM_FIFOS-1:0] commit_o,
    output logic [NUM_FIFOS-1:0] drop_o
);
    localparam int NP = 7 + SW + DATA_W;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [NP-1:0] s1;
        logic [NP-1:0] s2;
        logic clk_d;
        sfp_pkg::sfp_op_t op;
        logic [DATA_W-1:0] dout;
        logic oe;
        logic [NUM_FIFOS-1:0] emp;
        logic [NUM_FIFOS-1:0] ful;
        logic [NUM_FIFOS-1:0] cm;
        logic [NUM_FIFOS-1:0] dr;
    } sfp_top_t;

    sfp_top_t s_r, s_nxt;
    logic [NP-1:0] raw;
    logic edge_q;
    logic sel, oe_act, rd_act, wr_act, pk_act;
    logic [SW-1:0] fsel;
    logic [DATA_W-1:0] wdat;
    logic [DATA_W-1:0] head [NUM_FIFOS];
    logic [NUM_FIFOS-1:0] emp, ful, cm, dr;
    logic [NUM_FIFOS-1:0] wr_v, rd_v, pk_v;

    // All pins arrive from the master's domain: two flops before use
    assign raw = {interface_clock_i, port_select_n_i, bus_output_enable_i,
                  fifo_read_strobe_i, fifo_write_strobe_i,
                  packet_commit_strobe_i, 1'b0, fifo_select_lines_i,
                  data_i};

    // Decode synchronised pins; xor with polarity bit gives active level, inverted again for the low-active select
    assign edge_q = s_r.s2[NP-1] && !s_r.clk_d;
    assign sel = !(s_r.s2[NP-2] ^ polarity_i[`SFP_POL_SEL]);
    assign oe_act = s_r.s2[NP-3] ^ polarity_i[`SFP_POL_OE];
    assign rd_act = s_r.s2[NP-4] ^ polarity_i[`SFP_POL_RD];
    assign wr_act = s_r.s2[NP-5] ^ polarity_i[`SFP_POL_WR];
    assign pk_act = s_r.s2[NP-6] ^ polarity_i[`SFP_POL_PKT];
    assign fsel = s_r.s2[DATA_W+SW-1:DATA_W];
    assign wdat = s_r.s2[DATA_W-1:0];

    // Qualify strobes: select tied low (high with its polarity bit set) keeps the port selected
    always_comb begin
        for (int i = 0; i < NUM_FIFOS; i++) begin
            wr_v[i] = edge_q && sel && wr_act && fsel == SW'(i);
            rd_v[i] = edge_q && sel && rd_act && fsel == SW'(i);
            // Address held during commit is the one sampled
            pk_v[i] = edge_q && pk_act && fsel == SW'(i);
        end
    end

    // ------------------------------------------------------------
    // Endpoints, one per select address
    // ------------------------------------------------------------
    for (genvar g = 0; g < NUM_FIFOS; g++) begin : g_ep
        sfp_endpoint #(
            .DATA_W(DATA_W),
            .DEPTH(DEPTH),
            .AW(AW)
        ) u_ep (
            .core_clk_i(core_clk_i),
            .rst_n_i(rst_n_i),
            .wr_i(wr_v[g]),
            .rd_i(rd_v[g]),
            .commit_i(pk_v[g]),
            .edge_i(edge_q),
            .wdata_i(wdat),
            .auto_mode_i(auto_mode_i[g]),
            .auto_len_i(auto_commit_length_i),
            .head_o(head[g]),
            .empty_o(emp[g]),
            .full_o(ful[g]),
            .commit_o(cm[g]),
            .drop_o(dr[g])
        );
    end

    // Next state; head already reflects the advanced pointer
    always_comb begin
        s_nxt = s_r;
        s_nxt.s1 = raw;
        s_nxt.s2 = s_r.s1;
        s_nxt.clk_d = s_r.s2[NP-1];
        if (edge_q) begin
            s_nxt.op = (sel && rd_act) ? sfp_pkg::SFP_READ :
                       (sel && wr_act) ? sfp_pkg::SFP_WRITE :
                       sfp_pkg::SFP_IDLE;
        end
        s_nxt.dout = head[fsel]; // Prefetched word, no advance
        s_nxt.oe = oe_act; // Drive only under output enable
        s_nxt.emp = emp ^ {NUM_FIFOS{polarity_i[`SFP_POL_FLAG]}};
        s_nxt.ful = ful ^ {NUM_FIFOS{polarity_i[`SFP_POL_FLAG]}};
        s_nxt.cm = cm;
        s_nxt.dr = dr;
    end

    // Register all state
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_r <= '{op: sfp_pkg::SFP_IDLE, emp: '1, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from flops
    assign data_o = s_r.dout;
    assign data_oe_o = s_r.oe;
    assign empty_flag_o = s_r.emp;
    assign full_flag_o = s_r.ful;
    assign commit_o = s_r.cm;
    assign drop_o = s_r.dr;
endmodule

// *** test/sfp_port_sva.sv ***
// Checker of the slave FIFO port pin behaviour
module sfp_port_sva #(
    parameter int NUM_FIFOS = 4
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Link pins
    input wire logic interface_clock_i,
    input wire logic port_select_n_i,
    input wire logic bus_output_enable_i,
    input wire logic fifo_write_strobe_i,
    input wire logic [5:0] polarity_i,
    // Outputs
    input wire logic data_oe_o,
    input wire logic [NUM_FIFOS-1:0] empty_flag_o,
    input wire logic [NUM_FIFOS-1:0] commit_o,
    input wire logic [NUM_FIFOS-1:0] drop_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic lk_r;
    logic [3:0] gap_r;
    wire logic oe = bus_output_enable_i ^ polarity_i[1];
    wire logic wr = fifo_write_strobe_i ^ polarity_i[3];
    wire logic sel = port_select_n_i ~^ polarity_i[0];
    wire logic [NUM_FIFOS-1:0] emp = empty_flag_o ^ {NUM_FIFOS{polarity_i[5]}};
    // Age of the last link edge; saturates so long idle never wraps
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lk_r <= 1'b0;
            gap_r <= 4'hf;
        end else begin
            lk_r <= interface_clock_i;
            if (interface_clock_i && !lk_r) gap_r <= 4'h0;
            else if (gap_r != 4'hf) gap_r <= gap_r + 4'h1;
        end
    end
    sequence s_edge;
        !interface_clock_i ##1 interface_clock_i;
    endsequence
    sequence s_wr(logic s);
        s_edge ##0 (wr && sel == s);
    endsequence
    a_write_fills: assert property (s_wr(1'b1) ##0 (&emp)
        |-> ##[1:7] !$stable(empty_flag_o)) else $error("write lost");
    a_unsel_write: assert property (s_wr(1'b0)
        |-> ##1 $stable(empty_flag_o) [*7]) else $error("stray write");
    a_oe_drives: assert property ($rose(oe)
        |-> ##[1:4] data_oe_o) else $error("bus not driven");
    a_oe_quiet: assert property ((!oe) [*5]
        |-> !data_oe_o) else $error("bus driven without enable");
    a_commit_cause: assert property (commit_o != '0
        |-> gap_r < 4'ha) else $error("commit without link edge");
    a_drop_cause: assert property (drop_o != '0
        |-> gap_r < 4'ha) else $error("drop without link edge");
    a_commit_pulse: assert property (commit_o != '0
        |=> (commit_o & $past(commit_o)) == '0) else $error("long commit");
    a_drop_alone: assert property (drop_o != '0
        |-> (commit_o & drop_o) == '0) else $error("commit and drop");
endmodule
bind sfp_port sfp_port_sva #(.NUM_FIFOS(NUM_FIFOS)) u_sva (
    .core_clk_i, .rst_n_i, .interface_clock_i, .port_select_n_i,
    .bus_output_enable_i, .fifo_write_strobe_i, .polarity_i,
    .data_oe_o, .empty_flag_o, .commit_o, .drop_o
);

// *** test/sfp_master.sv ***
// Behavioural external master that drives the link pins
module sfp_master (
    // Pacing clock and pin polarity
    input wire logic clk_i,
    input wire logic [5:0] pol_i,
    // Link pins
    output logic lk_o,
    output logic sel_n_o,
    output logic oe_o,
    output logic rd_o,
    output logic wr_o,
    output logic pkt_o,
    output logic [1:0] adr_o,
    output logic [15:0] dat_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Link clock rests low between frames
    initial {lk_o, sel_n_o, oe_o, rd_o, wr_o, pkt_o, adr_o, dat_o} = 24'h400000;
    // One frame: c is select, enable, read, write, commit
    task automatic xf(input logic [4:0] c, input logic [1:0] a,
                      input logic [15:0] d);
        @(posedge clk_i);
        sel_n_o <= !c[4] ^ pol_i[0];
        oe_o <= c[3] ^ pol_i[1];
        rd_o <= c[2] ^ pol_i[2];
        wr_o <= c[1] ^ pol_i[3];
        pkt_o <= c[0] ^ pol_i[4];
        adr_o <= a;
        // A released bus shows the inverse so stale data never matches
        dat_o <= c[1] ? d : ~dat_o;
        repeat (4) @(posedge clk_i);
        lk_o <= 1'b1;
        // Back to back frames give a 400 ns link period
        repeat (3) @(posedge clk_i);
        lk_o <= 1'b0;
    endtask
endmodule

// *** test/sfp_port_bench.sv ***
// Self-checking bench of the slave FIFO port
module sfp_port_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst_n, lk, sn, oe, rd, wr, pk, doe;
    logic [5:0] pol;
    logic [3:0] am, emp, ful, cm, dr;
    logic [1:0] ad;
    logic [15:0] di, dq;
    logic [15:0] q[8];
    int fails, checks, cyc, i, g, n, seed;
    int nc[4], nd[4];
    sfp_port i_dut (.core_clk_i(clk), .rst_n_i(rst_n),
        .interface_clock_i(lk), .port_select_n_i(sn),
        .bus_output_enable_i(oe), .fifo_read_strobe_i(rd),
        .fifo_write_strobe_i(wr), .packet_commit_strobe_i(pk),
        .fifo_select_lines_i(ad), .data_i(di), .data_o(dq),
        .data_oe_o(doe), .polarity_i(pol), .auto_mode_i(am),
        .auto_commit_length_i(7'h4), .empty_flag_o(emp),
        .full_flag_o(ful), .commit_o(cm), .drop_o(dr));
    sfp_master i_mst (.clk_i(clk), .pol_i(pol), .lk_o(lk), .sel_n_o(sn),
        .oe_o(oe), .rd_o(rd), .wr_o(wr), .pkt_o(pk), .adr_o(ad), .dat_o(di));
    function automatic logic [15:0] fl(logic [3:0] raw);
        return {12'h0, raw ^ {4{pol[5]}}};
    endfunction
    // Callers let the outputs settle first; arguments are taken at the call
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic results;
        if (fails == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Packet event tally and hang guard
    always @(posedge clk) begin
        cyc++;
        for (int k = 0; k < 4; k++) begin
            nc[k] += cm[k];
            nd[k] += dr[k];
        end
        if (cyc == 4000) begin
            fails++;
            results();
        end
    end
    initial begin
        seed = 59;
        pol = 6'h00;
        am = 4'h4;
        rst_n = 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        n = 2 + $unsigned($random(seed)) % 5;
        for (i = 0; i < n; i++) begin
            q[i] = 16'($random(seed));
            i_mst.xf(5'h12, 2'h0, q[i]);
        end
        // Outputs settle one core cycle after the link edge is taken
        repeat (3) @(negedge clk);
        chk({12'h0, emp}, fl(4'he));
        i_mst.xf(5'h18, 2'h0, 16'h0);
        repeat (3) @(negedge clk);
        chk({15'h0, doe}, 16'h1);
        for (i = 0; i < n; i++) begin
            repeat (3) @(negedge clk);
            chk(dq, q[i]);
            i_mst.xf(5'h1c, 2'h0, 16'h0);
        end
        repeat (3) @(negedge clk);
        chk({12'h0, emp}, fl(4'hf));
        i_mst.xf(5'h02, 2'h1, 16'h1234);
        repeat (3) @(negedge clk);
        chk({15'h0, doe}, 16'h0);
        chk({12'h0, emp}, fl(4'hf));
        // Auto packets on FIFO 2: gapped short commit, then one too early
        for (g = 1; g >= 0; g--) begin
            for (i = 0; i < 4; i++) begin
                i_mst.xf(5'h12, 2'h2, 16'($random(seed)));
            end
            i_mst.xf(g ? 5'h12 : 5'h13, 2'h2, 16'h5);
            if (g) i_mst.xf(5'h11, 2'h2, 16'h0);
        end
        for (i = 0; i < 3; i++) begin
            i_mst.xf(i == 2 ? 5'h13 : 5'h12, 2'h3, 16'h7);
        end
        // Fill FIFO 1 to its depth; only its full flag may rise
        for (i = 0; i < 64; i++) begin
            i_mst.xf(5'h12, 2'h1, 16'(i));
        end
        repeat (3) @(negedge clk);
        chk({12'h0, ful}, fl(4'h2));
        chk(16'(nc[2]), 16'h3);
        chk(16'(nd[2]), 16'h1);
        chk(16'(nc[3]), 16'h1);
        // Select, enable, strobe and flag polarities inverted, taken up under a mid-run reset
        @(posedge clk);
        rst_n <= 1'b0;
        pol <= 6'h3f;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(negedge clk);
        chk({12'h0, emp}, 16'h0);
        chk({12'h0, ful}, 16'hf);
        i_mst.xf(5'h12, 2'h1, 16'h9);
        repeat (3) @(negedge clk);
        chk({12'h0, emp}, fl(4'hd));
        results();
    end
endmodule
